// ### pmc_pkg.sv
// Package of constants, types and register map for the power mode controller
// What this block does
// - Five power modes: normal, idle, stop, suspend, sleep, under one controller.
// - Writing idle-select halts the CPU once the writing instruction completes.
// - Idle keeps registers and memory; peripherals may keep running.
// - Enabled interrupt or reset ends idle; interrupt clears idle-select.
// - After idle wake the interrupt is serviced, then execution continues after the write.
// - Reset ending idle runs the normal reset sequence from address 0x0000.
// - Enabled watchdog keeps running in idle; its expiry resets and ends idle.
// - Stop-select halts CPU and precision oscillator; other oscillators untouched.
// - Only a reset ends stop; execution restarts at address 0x0000.
// - Enabled missing-clock detector reset ends stop; disable it for long stops.
// - Suspend-select gates the system clock and disables internal oscillators.
// - In suspend all digital logic stays stopped until an enabled wake source.
// - Four suspend wake sources: clock fail, alarm, port match, comparator rise.
// - Wake flags read zero for two system clocks after suspend wake.
// - A short reset-pin glitch still ends suspend; the code needs the pin low at two successive clock edges.
// - Configuration register shows whether last wake came from reset-pin fall.
// - Wake flags keep updating after wake, even for sources not enabled.
// - Suspend or sleep refused while any wake flag is set.
package pmc_pkg;

    // Register byte addresses
    localparam logic [3:0] PMC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] PMC_ADDR_WAKE = 4'h4;
    localparam logic [3:0] PMC_ADDR_FLSH = 4'h8;
    localparam logic [3:0] PMC_ADDR_STAT = 4'hC;

    // power_control_reg fields
    localparam int PMC_CTRL_IDLE_BIT = 0;
    localparam int PMC_CTRL_STOP_BIT = 1;

    // power_wake_config_reg fields
    localparam int PMC_WK_EN_LSB = 0;
    localparam int PMC_WK_SLEEP_BIT = 7;
    localparam int PMC_WK_SUSP_BIT = 6;
    localparam int PMC_WK_FLAG_LSB = 8;
    localparam int PMC_WK_RSTPIN_BIT = 12;

    // flash_scale_reg fields
    localparam int PMC_FL_BYPASS_BIT = 6;

    // Reset values
    localparam logic [3:0] PMC_WK_EN_RST = 4'h0;
    localparam logic [7:0] PMC_FLSH_RST = 8'h00;

    // Flags stay hidden this many clocks after suspend wake
    localparam logic [1:0] PMC_FLAG_HIDE_CYC = 2'h2;

    // Reset-pin wake re-entry guard, in ns and cycles
    localparam int PMC_CLK_PERIOD_NS = 5;
    localparam int PMC_RSTPIN_GUARD_NS = 15000;
    localparam int PMC_RSTPIN_GUARD_CYC = (PMC_RSTPIN_GUARD_NS + PMC_CLK_PERIOD_NS - 1) / PMC_CLK_PERIOD_NS;

    typedef enum {PMC_NORMAL, PMC_IDLE, PMC_STOP, PMC_SUSPEND, PMC_SLEEP, PMC_WAKE} pmc_mode_t;

    // Wake event group: clock fail, alarm, port match, comparator rise
    typedef struct packed {
        logic cmp_rise;
        logic port_match;
        logic rtc_alarm;
        logic rtc_fail;
    } pmc_wake_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } pmc_avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } pmc_avm_rsp_t;

    typedef struct packed {
        pmc_mode_t mode;
        logic idle_sel;
        logic stop_sel;
        logic [3:0] wake_en;
        logic [3:0] wake_flag;
        logic rstpin_flag;
        logic [7:0] flash_scale;
        logic [1:0] hide_cnt;
        logic [12:0] guard_cnt;
        logic rst_s1;
        logic rst_s2;
        logic rst_s3;
        logic [3:0] ev_s1;
        logic [3:0] ev_s2;
        logic [3:0] ev_s3;
        logic [3:0] ev_prev;
        logic ack;
        logic [31:0] rdata;
        logic refused;
    } pmc_state_t;

endpackage : pmc_pkg

// ### pmc_power_mode_unit.sv
// Power mode unit: mode sequencing, wake flags and Avalon-MM registers
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module pmc_power_mode_unit
    import pmc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire pmc_avm_req_t avm_req,
    output pmc_avm_rsp_t avm_rsp,
    // CPU side
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic wdt_expired,
    input wire logic mcd_expired,
    // Pins and wake events, asynchronous
    input wire logic rst_n_pin,
    input wire pmc_wake_t wake_ev,
    // Controls out
    output logic cpu_halt,
    output logic sysclk_gate,
    output logic precision_osc_en,
    output logic internal_osc_en,
    output logic sys_reset_req,
    output logic flash_oneshot_bypass,
    output logic [2:0] power_mode
);

    pmc_state_t s_q;
    pmc_state_t s_d;

    logic wr_hit;
    logic rd_hit;
    logic [3:0] ev_rise;
    logic pin_fall;
    logic any_reset;
    logic [31:0] rd_val;

    always_comb begin
        // Write lands only at the edge where waitrequest is low
        wr_hit = avm_req.write && s_q.ack;
        rd_hit = avm_req.read && !s_q.ack;
        // Edge only counts once stages two and three agree
        ev_rise = (s_q.ev_s2 & s_q.ev_s3) & ~s_q.ev_prev;
        pin_fall = !s_q.rst_s2 && !s_q.rst_s3 && s_q.rstpin_flag == 1'b0 && s_q.guard_cnt == 13'h0000 ? 1'b1 : 1'b0;
        any_reset = wdt_expired || mcd_expired;
        rd_val = 32'h0000_0000;
        case (avm_req.address)
            PMC_ADDR_CTRL: begin
                rd_val[PMC_CTRL_IDLE_BIT] = s_q.idle_sel;
                rd_val[PMC_CTRL_STOP_BIT] = s_q.stop_sel;
            end
            PMC_ADDR_WAKE: begin
                rd_val[PMC_WK_EN_LSB +: 4] = s_q.wake_en;
                rd_val[PMC_WK_SUSP_BIT] = s_q.mode == PMC_SUSPEND;
                rd_val[PMC_WK_SLEEP_BIT] = s_q.mode == PMC_SLEEP;
                if (s_q.hide_cnt == 2'h0) begin
                    rd_val[PMC_WK_FLAG_LSB +: 4] = s_q.wake_flag;
                    rd_val[PMC_WK_RSTPIN_BIT] = s_q.rstpin_flag;
                end
            end
            PMC_ADDR_FLSH: rd_val[7:0] = s_q.flash_scale;
            PMC_ADDR_STAT: begin
                rd_val[2:0] = 3'(s_q.mode);
                rd_val[3] = s_q.refused;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.ack = (avm_req.read || avm_req.write) && !s_q.ack;
        s_d.rdata = rd_hit ? rd_val : s_q.rdata;
        s_d.rst_s1 = rst_n_pin;
        s_d.rst_s2 = s_q.rst_s1;
        s_d.rst_s3 = s_q.rst_s2;
        s_d.ev_s1 = wake_ev;
        s_d.ev_s2 = s_q.ev_s1;
        s_d.ev_s3 = s_q.ev_s2;
        if (s_q.ev_s2 == s_q.ev_s3) begin
            s_d.ev_prev = s_q.ev_s3;
        end
        if (s_q.hide_cnt != 2'h0) begin
            s_d.hide_cnt = s_q.hide_cnt - 2'h1;
        end
        if (s_q.guard_cnt != 13'h0000) begin
            s_d.guard_cnt = s_q.guard_cnt - 13'h0001;
        end
        // Software writes; flags written as one clear
        if (wr_hit) begin
            case (avm_req.address)
                PMC_ADDR_CTRL: begin
                    s_d.idle_sel = avm_req.writedata[PMC_CTRL_IDLE_BIT];
                    s_d.stop_sel = avm_req.writedata[PMC_CTRL_STOP_BIT];
                end
                PMC_ADDR_WAKE: begin
                    // Enables written with the suspend request
                    s_d.wake_en = avm_req.writedata[PMC_WK_EN_LSB +: 4];
                    s_d.wake_flag = s_q.wake_flag & ~avm_req.writedata[PMC_WK_FLAG_LSB +: 4];
                    if (avm_req.writedata[PMC_WK_RSTPIN_BIT]) begin
                        s_d.rstpin_flag = 1'b0;
                    end
                    s_d.refused = 1'b0;
                    // Refuse low power while a flag is set
                    if (s_q.wake_flag != 4'h0 || s_q.rstpin_flag || s_q.guard_cnt != 13'h0000) begin
                        s_d.refused = avm_req.writedata[PMC_WK_SUSP_BIT] || avm_req.writedata[PMC_WK_SLEEP_BIT];
                    end else if (avm_req.writedata[PMC_WK_SLEEP_BIT]) begin
                        s_d.mode = PMC_SLEEP;
                    end else if (avm_req.writedata[PMC_WK_SUSP_BIT]) begin
                        s_d.mode = PMC_SUSPEND;
                    end
                end
                // Software clears bypass before idle or stop
                PMC_ADDR_FLSH: s_d.flash_scale = avm_req.writedata[7:0];
                default: s_d.refused = s_q.refused;
            endcase
        end
        // Flags update always; set wins over clear
        s_d.wake_flag = s_d.wake_flag | ev_rise;
        // Reset-pin fall, seen low at sync stages two and three together
        if (pin_fall) begin
            s_d.rstpin_flag = 1'b1;
        end
        case (s_q.mode)
            PMC_NORMAL: begin
                // Enter idle after the writing instruction
                if (s_q.idle_sel && instr_done) begin
                    s_d.mode = PMC_IDLE;
                // Enter stop after the writing instruction
                end else if (s_q.stop_sel && instr_done) begin
                    s_d.mode = PMC_STOP;
                end
            end
            PMC_IDLE: begin
                // Interrupt ends idle and clears select
                // CPU resumes to service the interrupt
                if (irq_pending) begin
                    s_d.idle_sel = 1'b0;
                    s_d.mode = PMC_NORMAL;
                end
            end
            PMC_STOP: s_d.mode = PMC_STOP;
            PMC_SUSPEND, PMC_SLEEP: begin
                // Held until an enabled source, pin fall or watchdog or missing-clock reset
                if ((ev_rise & s_q.wake_en) != 4'h0 || pin_fall) begin
                    s_d.mode = PMC_WAKE;
                    s_d.hide_cnt = PMC_FLAG_HIDE_CYC;
                    s_d.wake_en = 4'h0;
                    // Guard period after a pin wake
                    if (pin_fall) begin
                        s_d.guard_cnt = 13'(PMC_RSTPIN_GUARD_CYC);
                    end
                end
            end
            PMC_WAKE: s_d.mode = PMC_NORMAL;
            default: s_d.mode = PMC_NORMAL;
        endcase
        // Reset leaves any mode through the reset sequence
        if (any_reset) begin
            s_d.mode = PMC_NORMAL;
            s_d.idle_sel = 1'b0;
            s_d.stop_sel = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '{mode: PMC_NORMAL, idle_sel: 1'b0, stop_sel: 1'b0, wake_en: PMC_WK_EN_RST,
                     wake_flag: 4'h0, rstpin_flag: 1'b0, flash_scale: PMC_FLSH_RST, hide_cnt: 2'h0,
                     guard_cnt: 13'h0000, rst_s1: 1'b1, rst_s2: 1'b1, rst_s3: 1'b1, ev_s1: 4'h0,
                     ev_s2: 4'h0, ev_s3: 4'h0, ev_prev: 4'h0, ack: 1'b0, rdata: 32'h0000_0000,
                     refused: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Waitrequest high until the registered answer is ready
    assign avm_rsp.waitrequest = (avm_req.read || avm_req.write) && !s_q.ack;
    assign avm_rsp.readdata = s_q.rdata;

    // Idle halts only the CPU; peripheral clock runs
    assign cpu_halt = s_q.mode != PMC_NORMAL;
    // Clock gated, oscillators off in suspend and sleep
    assign sysclk_gate = s_q.mode == PMC_SUSPEND || s_q.mode == PMC_SLEEP;
    assign internal_osc_en = !sysclk_gate;
    // Precision oscillator stopped in stop mode
    assign precision_osc_en = !sysclk_gate && s_q.mode != PMC_STOP;
    // Reset request restarts the CPU at address zero
    assign sys_reset_req = any_reset;
    assign flash_oneshot_bypass = s_q.flash_scale[PMC_FL_BYPASS_BIT];
    assign power_mode = 3'(s_q.mode);

endmodule : pmc_power_mode_unit

// ### pmc_power_mode_unit_monitor.sv
// Port checker of the power mode unit, bound to the design
`timescale 1ns/10ps
module pmc_power_mode_unit_monitor
    import pmc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // CPU side
    input wire logic irq_pending,
    input wire logic wdt_expired,
    input wire logic mcd_expired,
    // Controls out
    input wire logic cpu_halt,
    input wire logic sysclk_gate,
    input wire logic precision_osc_en,
    input wire logic internal_osc_en,
    input wire logic [2:0] power_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    reset_normal_a: assert property ($fell(rst) |-> power_mode == 3'h0 && !cpu_halt)
        else $error("mode not normal after reset");
    idle_clock_a: assert property (power_mode == 3'h1 |-> cpu_halt && !sysclk_gate)
        else $error("idle stopped the clock");
    idle_irq_exit_a: assert property (power_mode == 3'h1 && irq_pending |=> power_mode == 3'h0)
        else $error("interrupt did not end idle");
    idle_wdt_exit_a: assert property (power_mode == 3'h1 && wdt_expired |=> power_mode == 3'h0 && !cpu_halt)
        else $error("watchdog did not end idle");
    stop_entry_a: assert property ($rose(power_mode == 3'h2) |-> !precision_osc_en && cpu_halt)
        else $error("stop left precision oscillator on");
    stop_hold_a: assert property (power_mode == 3'h2 && !wdt_expired && !mcd_expired |=> power_mode == 3'h2)
        else $error("stop ended without reset");
    stop_mcd_exit_a: assert property (power_mode == 3'h2 && mcd_expired |=> power_mode == 3'h0)
        else $error("missing clock reset did not end stop");
    suspend_gate_a: assert property (power_mode == 3'h3 |-> sysclk_gate && !internal_osc_en && !precision_osc_en)
        else $error("suspend left clock or oscillators on");
endmodule : pmc_power_mode_unit_monitor

bind pmc_power_mode_unit pmc_power_mode_unit_monitor i_mon (.core_clk, .rst, .irq_pending, .wdt_expired,
    .mcd_expired, .cpu_halt, .sysclk_gate, .precision_osc_en, .internal_osc_en, .power_mode);

// ### power_mode_controller_tb.sv
// Self-checking bench of the power mode unit
`timescale 1ns/10ps
module power_mode_controller_tb
    import pmc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_done = 1'b0;
    logic irq_pending = 1'b0;
    logic wdt_expired = 1'b0;
    logic mcd_expired = 1'b0;
    logic rst_n_pin = 1'b1;
    pmc_avm_req_t req = '0;
    pmc_avm_rsp_t rsp;
    pmc_wake_t wake_ev = '0;
    logic cpu_halt, sysclk_gate, pos_en, ios_en, rst_req, bypass;
    logic [2:0] power_mode;
    logic [31:0] rd;
    logic [3:0] ad [5] = '{PMC_ADDR_CTRL, PMC_ADDR_WAKE, PMC_ADDR_FLSH, PMC_ADDR_STAT, 4'h2};
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    pmc_power_mode_unit i_dut (.core_clk(core_clk), .rst(rst), .avm_req(req), .avm_rsp(rsp),
        .instr_done(instr_done), .irq_pending(irq_pending), .wdt_expired(wdt_expired),
        .mcd_expired(mcd_expired), .rst_n_pin(rst_n_pin), .wake_ev(wake_ev), .cpu_halt(cpu_halt),
        .sysclk_gate(sysclk_gate), .precision_osc_en(pos_en), .internal_osc_en(ios_en),
        .sys_reset_req(rst_req), .flash_oneshot_bypass(bypass), .power_mode(power_mode));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // A hang counts as a mismatch
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Request held until waitrequest is seen low at an edge
    task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{address: a, read: !w, write: w, writedata: d};
        @(posedge core_clk);
        while (rsp.waitrequest !== 1'b0) @(posedge core_clk);
        rd = rsp.readdata;
        req <= '0;
    endtask : acc

    // One-cycle pulse: 0 instr_done, 1 irq_pending, 2 wdt_expired, 3 mcd_expired
    task automatic pulse(input int which);
        case (which)
            0: instr_done <= 1'b1;
            1: irq_pending <= 1'b1;
            2: wdt_expired <= 1'b1;
            default: mcd_expired <= 1'b1;
        endcase
        @(posedge core_clk);
        instr_done <= 1'b0;
        irq_pending <= 1'b0;
        wdt_expired <= 1'b0;
        mcd_expired <= 1'b0;
    endtask : pulse

    task automatic await(input logic [2:0] m);
        int i;
        for (i = 0; i < 40 && power_mode !== m; i++) @(posedge core_clk);
        chk(32'(power_mode), 32'(m));
    endtask : await

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        foreach (ad[i]) begin
            acc(ad[i], 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        acc(PMC_ADDR_FLSH, 1'b1, 32'h40);
        @(posedge core_clk);
        chk(32'(bypass), 32'h1);
        acc(PMC_ADDR_FLSH, 1'b1, 32'h0);
        $display("test registers done");
        acc(PMC_ADDR_CTRL, 1'b1, 32'h1);
        chk(32'(power_mode), 32'h0);
        pulse(0);
        await(3'h1);
        pulse(1);
        await(3'h0);
        acc(PMC_ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        acc(PMC_ADDR_CTRL, 1'b1, 32'h1);
        pulse(0);
        await(3'h1);
        pulse(2);
        await(3'h0);
        $display("test idle done");
        acc(PMC_ADDR_CTRL, 1'b1, 32'h2);
        pulse(0);
        await(3'h2);
        pulse(1);
        repeat (4) @(posedge core_clk);
        chk(32'(power_mode), 32'h2);
        pulse(3);
        await(3'h0);
        $display("test stop done");
        // Clock source choice lies outside; bench keeps one clock
        // Each source in turn; a different, disabled source must not wake
        for (int b = 0; b < 4; b++) begin
            acc(PMC_ADDR_WAKE, 1'b1, 32'h40 | (1 << b));
            await(3'h3);
            wake_ev <= 4'(1 << ((b + 1) % 4));
            repeat (8) @(posedge core_clk);
            chk(32'(power_mode), 32'h3);
            wake_ev <= 4'((1 << b) | (1 << ((b + 1) % 4)));
            // Three sync stages, then the read is taken in the hidden window
            repeat (3) @(posedge core_clk);
            acc(PMC_ADDR_WAKE, 1'b0, 32'h0);
            chk(rd & 32'h1F00, 32'h0);
            chk(32'(power_mode), 32'h0);
            wake_ev <= '0;
            acc(PMC_ADDR_WAKE, 1'b0, 32'h0);
            chk(32'(rd[8 + b]), 32'h1);
            acc(PMC_ADDR_WAKE, 1'b1, 32'h1F00);
        end
        $display("test suspend done");
        wake_ev <= 4'h2;
        repeat (6) @(posedge core_clk);
        wake_ev <= '0;
        acc(PMC_ADDR_WAKE, 1'b0, 32'h0);
        chk(32'(rd[9]), 32'h1);
        acc(PMC_ADDR_WAKE, 1'b1, 32'h48);
        acc(PMC_ADDR_STAT, 1'b0, 32'h0);
        chk(rd & 32'hF, 32'h8);
        acc(PMC_ADDR_WAKE, 1'b1, 32'h1F00);
        $display("test flags done");
        acc(PMC_ADDR_WAKE, 1'b1, 32'h40);
        await(3'h3);
        rst_n_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n_pin <= 1'b1;
        await(3'h0);
        acc(PMC_ADDR_WAKE, 1'b0, 32'h0);
        chk(32'(rd[12]), 32'h1);
        // Suspend again too soon after a pin wake
        acc(PMC_ADDR_WAKE, 1'b1, 32'h1000);
        acc(PMC_ADDR_WAKE, 1'b1, 32'h40);
        acc(PMC_ADDR_STAT, 1'b0, 32'h0);
        chk(rd & 32'hF, 32'h8);
        $display("test reset pin done");
        conclude();
    end
endmodule : power_mode_controller_tb
